//--- rtl/cpu_int_bus_ctl.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpu_ctl_map.svh"

module cpu_int_bus_ctl
  import cpu_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Device pins
  input  wire logic        reset_in_n,
  input  wire logic        nmi_n,
  input  wire logic        ready,
  input  wire logic        bus_handover_enable,
  input  wire logic        ext_rom_select,
  input  wire logic        maskable_request_a_in,
  input  wire logic        maskable_request_b_in,
  output var  logic        maskable_request_a_out,
  output var  logic        maskable_request_a_oe_n,
  output var  logic        maskable_request_b_out,
  output var  logic        maskable_request_b_oe_n,
  input  wire logic        rw_in,
  output var  logic        rw_out,
  output var  logic        rw_oe_n,
  output var  logic        addr_oe_n,
  output var  logic        data_oe_n,
  output var  logic        phi2,
  output var  logic        phi4,
  output var  logic        sync,
  output var  logic        rmw_lock_out_n,
  // Core side
  input  wire core_cycle_s core_cycle,
  input  wire logic        core_i_flag,
  input  wire logic        src_timer,
  input  wire logic        src_row_rx,
  input  wire logic [15:0] core_addr,
  output var  logic        core_step,
  output var  logic        core_halted,
  output var  logic        ext_access,
  output var  logic        ext_rw_read,
  output var  int_start_s  int_start,
  output var  logic        set_i_flag,
  output var  logic        test_mode,
  output var  logic        rom_to_external
);

  // ----------------------------------------------------------------
  // Phase generation
  // ----------------------------------------------------------------
  logic phi2_i;
  logic phi4_i;
  logic rise_en;
  logic fall_en;

  phase_gen #(
    .HALF (`PHI_HALF_CLKS)
  ) u_phase (
    .clk     (clk),
    .rst     (rst),
    .phi2    (phi2_i),
    .phi4    (phi4_i),
    .rise_en (rise_en),
    .fall_en (fall_en)
  );

  // Vector select for the wire-ORed maskable lines (active low levels)
  function automatic logic [15:0] irq_vector(input logic a_n, input logic b_n);
    if (!a_n && !b_n)
      irq_vector = `VEC_ROW_RX;
    else if (!b_n)
      irq_vector = `VEC_EXTERNAL;
    else
      irq_vector = `VEC_TIMER;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  seq_e        seq;
  logic [2:0]  init_cnt;
  logic        reset_prev;
  logic        be_at_release;
  logic        test_check;
  logic        nmi_prev;
  logic        nmi_pending;
  logic        irq_a_s;
  logic        irq_b_s;
  logic        stalled;
  logic        be_s;

  seq_e        next_seq;
  logic [2:0]  next_init_cnt;
  logic        next_be_at_release;
  logic        next_test_check;
  logic        next_test_mode;
  logic        next_nmi_prev;
  logic        next_nmi_pending;
  logic        next_irq_a_s;
  logic        next_irq_b_s;
  logic        next_stalled;
  logic        next_step;
  int_start_s  next_int_start;
  logic        next_sync;
  logic        next_lock_n;
  logic        next_rw_out;
  logic        next_rw_oe_n;
  logic        next_addr_oe_n;
  logic        next_data_oe_n;
  logic        next_a_oe_n;
  logic        next_b_oe_n;
  logic        next_rom_ext;
  logic        nmi_edge;
  logic        irq_live;
  logic        advance;

  // ----------------------------------------------------------------
  // Sequencing, exceptions and bus steering
  // ----------------------------------------------------------------
  always_comb
  begin
    next_seq           = seq;
    next_init_cnt      = init_cnt;
    next_be_at_release = be_at_release;
    next_test_check    = 1'b0;
    next_test_mode     = test_mode;
    next_nmi_prev      = nmi_prev;
    next_nmi_pending   = nmi_pending;
    next_irq_a_s       = irq_a_s;
    next_irq_b_s       = irq_b_s;
    next_stalled       = stalled;
    next_step          = 1'b0;
    next_int_start     = '0;
    next_sync          = sync;
    next_lock_n        = rmw_lock_out_n;
    nmi_edge           = 1'b0;

    // Pins sampled in the last clock of phi2 high
    if (fall_en)
    begin
      next_irq_a_s  = maskable_request_a_in;
      next_irq_b_s  = maskable_request_b_in;
      next_nmi_prev = nmi_n;
      nmi_edge      = nmi_prev && !nmi_n;
    end
    // Set wins over the clear at service start
    if (nmi_edge)
      next_nmi_pending = 1'b1;

    // Ready sampled at the end of phi2 low, takes effect at phi2 rise
    if (rise_en)
      next_stalled = !ready && (seq != SEQ_HELD);

    // Cycle advances at phi2 fall unless stalled or bus handed over
    advance = fall_en && !stalled && be_s && (seq == SEQ_RUN);
    // Level check: a line released before the flag clears is gone
    irq_live = (!irq_a_s || !irq_b_s) && !core_i_flag;

    case (seq)
      SEQ_HELD:
      begin
        next_init_cnt = '0;
        if (reset_in_n && !reset_prev)
        begin
          next_seq           = SEQ_INIT;
          next_be_at_release = bus_handover_enable;
          next_test_check    = 1'b1;
        end
      end
      SEQ_INIT:
      begin
        // Six phi2 cycles before the reset vector is taken
        if (fall_en)
        begin
          next_init_cnt = init_cnt + 3'h1;
          if (init_cnt == `RESET_SEQ_CYCLES - 3'h1)
          begin
            next_seq                = SEQ_RUN;
            next_int_start.start    = 1'b1;
            next_int_start.is_reset = 1'b1;
            next_int_start.vector   = `VEC_RESET;
            next_step               = 1'b1;
          end
        end
      end
      SEQ_RUN:
      begin
        if (advance)
        begin
          next_step = 1'b1;
          if (core_cycle.last_of_instr && (nmi_pending || nmi_edge))
          begin
            next_int_start.start  = 1'b1;
            next_int_start.is_nmi = 1'b1;
            next_int_start.vector = `VEC_NMI;
            next_nmi_pending      = nmi_pending && nmi_edge; // Newer edge survives
          end
          else if (core_cycle.last_of_instr && irq_live)
          begin
            next_int_start.start  = 1'b1;
            next_int_start.vector = irq_vector(irq_a_s, irq_b_s);
          end
          // Cycle-type outputs follow the cycle now starting
          next_sync   = core_cycle.opcode_fetch;
          next_lock_n = !(core_cycle.rmw_modify || core_cycle.rmw_write);
        end
        else if (fall_en && !stalled)
        begin
          next_sync   = 1'b0;
          next_lock_n = 1'b1;
        end
      end
      default:
        next_seq = SEQ_HELD;
    endcase

    // Test mode: low at release and still low one clock later
    if (test_check)
      next_test_mode = !be_at_release && !bus_handover_enable;
    next_rom_ext = test_mode && ext_rom_select
                   && (core_addr >= `ROM_LO) && (core_addr <= `ROM_HI);

    // Bus direction follows bus enable in run; held and init states drive the bus regardless
    if (be_s || seq != SEQ_RUN)
    begin
      next_rw_oe_n   = 1'b0;
      next_rw_out    = (seq != SEQ_RUN) || core_cycle.read;
      next_addr_oe_n = 1'b0;
      next_data_oe_n = !(phi2_i && !core_cycle.read && seq == SEQ_RUN);
    end
    else
    begin
      next_rw_oe_n   = 1'b1;
      next_rw_out    = 1'b1;
      next_addr_oe_n = 1'b1;
      next_data_oe_n = !(rw_in && phi2_i);
    end

    // Internal sources pull the shared lines low
    next_a_oe_n = !(src_timer || src_row_rx);
    next_b_oe_n = !src_row_rx;

    if (!reset_in_n)
    begin
      next_seq         = SEQ_HELD;
      next_stalled     = 1'b0;
      next_nmi_pending = 1'b0;
      next_sync        = 1'b0;
      next_lock_n      = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers; all top outputs come from here
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      seq                     <= SEQ_HELD;
      init_cnt                <= 3'h0;
      reset_prev              <= 1'b0;
      be_at_release           <= 1'b1;
      test_check              <= 1'b0;
      test_mode               <= 1'b0;
      nmi_prev                <= 1'b1;
      nmi_pending             <= 1'b0;
      irq_a_s                 <= 1'b1;
      irq_b_s                 <= 1'b1;
      stalled                 <= 1'b0;
      be_s                    <= 1'b1;
      core_step               <= 1'b0;
      core_halted             <= 1'b0;
      ext_access              <= 1'b0;
      ext_rw_read             <= 1'b1;
      int_start               <= '0;
      set_i_flag              <= 1'b0;
      sync                    <= 1'b0;
      rmw_lock_out_n          <= 1'b1;
      rw_out                  <= 1'b1;
      rw_oe_n                 <= 1'b0;
      addr_oe_n               <= 1'b0;
      data_oe_n               <= 1'b1;
      maskable_request_a_out  <= 1'b0;
      maskable_request_a_oe_n <= 1'b1;
      maskable_request_b_out  <= 1'b0;
      maskable_request_b_oe_n <= 1'b1;
      phi2                    <= 1'b0;
      phi4                    <= 1'b0;
      rom_to_external         <= 1'b0;
    end
    else
    begin
      seq                     <= next_seq;
      init_cnt                <= next_init_cnt;
      reset_prev              <= reset_in_n;
      be_at_release           <= next_be_at_release;
      test_check              <= next_test_check;
      test_mode               <= next_test_mode;
      nmi_prev                <= next_nmi_prev;
      nmi_pending             <= next_nmi_pending;
      irq_a_s                 <= next_irq_a_s;
      irq_b_s                 <= next_irq_b_s;
      stalled                 <= next_stalled;
      be_s                    <= bus_handover_enable;
      core_step               <= next_step;
      core_halted             <= next_stalled;       // Address and data frozen
      ext_access              <= !be_s && (seq == SEQ_RUN);
      ext_rw_read             <= rw_in;
      int_start               <= next_int_start;
      set_i_flag              <= next_int_start.start;
      sync                    <= next_sync;
      rmw_lock_out_n          <= next_lock_n;
      rw_out                  <= next_rw_out;
      rw_oe_n                 <= next_rw_oe_n;
      addr_oe_n               <= next_addr_oe_n;
      data_oe_n               <= next_data_oe_n;
      maskable_request_a_out  <= 1'b0;
      maskable_request_a_oe_n <= next_a_oe_n;
      maskable_request_b_out  <= 1'b0;
      maskable_request_b_oe_n <= next_b_oe_n;
      phi2                    <= phi2_i;
      phi4                    <= phi4_i;
      rom_to_external         <= next_rom_ext;
    end
  end

endmodule

`default_nettype wire

//--- inc/cpu_ctl_map.svh
`ifndef CPU_CTL_MAP_SVH
`define CPU_CTL_MAP_SVH

// ----------------------------------------------------------------
// Vector addresses
// ----------------------------------------------------------------
`define VEC_ROW_RX      16'hfff8
`define VEC_EXTERNAL    16'hfffa
`define VEC_TIMER       16'hfffc
`define VEC_NMI         16'hffec
`define VEC_RESET       16'hffee

// ----------------------------------------------------------------
// Internal ROM window that test mode can hand to external memory
// ----------------------------------------------------------------
`define ROM_LO          16'hf800
`define ROM_HI          16'hffff

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define RESET_SEQ_CYCLES 3'h6
`define PHI_HALF_CLKS    2

`endif

//--- inc/cpu_ctl_pkg.sv
package cpu_ctl_pkg;

  // Per-bus-cycle description coming from the core sequencer
  typedef struct packed {
    logic opcode_fetch;
    logic rmw_modify;
    logic rmw_write;
    logic last_of_instr;
    logic read;
  } core_cycle_s;

  // Exception start request handed to the core
  typedef struct packed {
    logic        start;
    logic        is_nmi;
    logic        is_reset;
    logic [15:0] vector;
  } int_start_s;

  typedef enum logic [1:0] {
    SEQ_HELD,
    SEQ_INIT,
    SEQ_RUN
  } seq_e;

endpackage

//--- rtl/phase_gen.sv
`timescale 1ns/1ps
`default_nettype none

module phase_gen
  import cpu_ctl_pkg::*;
#(
  parameter int HALF = 2
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Phase outputs
  output var  logic phi2,
  output var  logic phi4,
  output var  logic rise_en,
  output var  logic fall_en
);

  localparam int CW = $clog2(2 * HALF);

  // Strobe decode needs two clocks in each half
  if (HALF < 2)
  begin
    $error("HALF must be at least 2");
  end

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_phi2;
  logic          next_phi4;
  logic          next_rise;
  logic          next_fall;

  // ----------------------------------------------------------------
  // Phase counter, free running even while the bus is handed over
  // ----------------------------------------------------------------
  always_comb
  begin
    next_cnt  = (cnt == CW'(2 * HALF - 1)) ? '0 : cnt + 1'b1;
    next_phi2 = (next_cnt >= CW'(HALF));
    // Quarter-cycle lag so phi4 trails phi2
    next_phi4 = (next_cnt >= CW'(HALF + HALF / 2)) || (next_cnt < CW'(HALF / 2));
    next_rise = (cnt == CW'(HALF - 2));      // Last clock of phi2 low follows
    next_fall = (cnt == CW'(2 * HALF - 2));  // Last clock of phi2 high follows
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt     <= '0;
      phi2    <= 1'b0;
      phi4    <= 1'b0;
      rise_en <= 1'b0;
      fall_en <= 1'b0;
    end
    else
    begin
      cnt     <= next_cnt;
      phi2    <= next_phi2;
      phi4    <= next_phi4;
      rise_en <= next_rise;
      fall_en <= next_fall;
    end
  end

endmodule

`default_nettype wire

//--- tb/cpu_ctl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Port-level checks of the control block
// ----------------------------------------------------------------
module cpu_ctl_checks
  import cpu_ctl_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Device pins
  input wire logic       reset_in_n,
  input wire logic       ready,
  input wire logic       bus_handover_enable,
  input wire logic       maskable_request_a_out,
  input wire logic       maskable_request_a_oe_n,
  input wire logic       maskable_request_b_oe_n,
  input wire logic       rw_oe_n,
  input wire logic       phi2,
  input wire logic       phi4,
  input wire logic       sync,
  input wire logic       rmw_lock_out_n,
  // Core side
  input wire logic       src_timer,
  input wire logic       src_row_rx,
  input wire logic       core_step,
  input wire int_start_s int_start,
  input wire logic       set_i_flag,
  input wire logic       test_mode
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Pull-downs follow the internal sources one clock later; reset cycle skipped
  property p_pull_a;
    !$past(rst) |-> maskable_request_a_oe_n == !$past(src_timer || src_row_rx);
  endproperty
  a_pull_a: assert property (p_pull_a) else $error("line a pull wrong");
  property p_pull_b;
    !$past(rst) |-> !maskable_request_a_out && maskable_request_b_oe_n == !$past(src_row_rx);
  endproperty
  a_pull_b: assert property (p_pull_b) else $error("line b pull wrong");
  property p_phase;
    $rose(phi2) |=> phi2 ##1 !phi2 [*2] ##1 phi2;
  endproperty
  a_phase: assert property (p_phase) else $error("phi2 period broken");
  property p_phi4_lag;
    $rose(phi2) |-> !phi4 ##1 phi4 [*2] ##1 !phi4;
  endproperty
  a_phi4_lag: assert property (p_phi4_lag) else $error("phi4 phase wrong");
  property p_handover_stop;
    !bus_handover_enable [*3] |=> !core_step;
  endproperty
  a_handover_stop: assert property (p_handover_stop) else $error("step while handed over");
  property p_ready_stop;
    !ready [*3] |=> !core_step;
  endproperty
  a_ready_stop: assert property (p_ready_stop) else $error("step while not ready");
  property p_entry;
    int_start.start |-> core_step && set_i_flag ##1 (!set_i_flag && !core_step && !int_start.start);
  endproperty
  a_entry: assert property (p_entry) else $error("entry pulses wrong");
  property p_vector;
    int_start.start |-> (int_start.is_reset ? int_start.vector == 16'hffee :
      int_start.is_nmi ? int_start.vector == 16'hffec :
      int_start.vector inside {16'hfff8, 16'hfffa, 16'hfffc});
  endproperty
  a_vector: assert property (p_vector) else $error("vector wrong");
  property p_rw_drive;
    bus_handover_enable [*3] |=> !rw_oe_n;
  endproperty
  a_rw_drive: assert property (p_rw_drive) else $error("read/write not driven");
  property p_sync_len;
    $rose(sync) |-> sync [*4];
  endproperty
  a_sync_len: assert property (p_sync_len) else $error("sync too short");
  property p_lock_len;
    $fell(rmw_lock_out_n) |-> !rmw_lock_out_n [*4];
  endproperty
  a_lock_len: assert property (p_lock_len) else $error("lock too short");
  property p_mode_hold;
    reset_in_n [*4] |=> $stable(test_mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed in run");
endmodule

bind cpu_int_bus_ctl cpu_ctl_checks cpu_ctl_checks_i (.clk, .rst, .reset_in_n, .ready,
  .bus_handover_enable, .maskable_request_a_out, .maskable_request_a_oe_n,
  .maskable_request_b_oe_n, .rw_oe_n, .phi2, .phi4, .sync, .rmw_lock_out_n, .src_timer,
  .src_row_rx, .core_step, .int_start, .set_i_flag, .test_mode);
`default_nettype wire

//--- tb/ext_side_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Far side: pulled-up request lines, host, slow memory
// ----------------------------------------------------------------
module ext_side_model (
  // Clock
  input  wire logic clk,
  // Scenario controls
  input  wire logic host_owns,
  input  wire logic host_read,
  input  wire logic ext_pull_b,
  input  wire logic slow,
  // Device pins
  input  wire logic a_oe_n,
  input  wire logic b_oe_n,
  input  wire logic rw_out,
  input  wire logic rw_oe_n,
  output var  logic a_pin,
  output var  logic b_pin,
  output var  logic rw_line,
  output var  logic ready
);
  logic [2:0] cnt     = 3'h0;
  logic       last_rw = 1'b1;

  // Free count paces wait states; last level kept for the undriven line
  always_ff @(posedge clk)
  begin
    cnt     <= cnt + 3'h1;
    last_rw <= rw_line;
  end
  // Wired lines: low while any party pulls
  assign a_pin = a_oe_n;
  assign b_pin = b_oe_n & ~ext_pull_b;
  // Nobody driving shows the inverse, so a stale value never looks valid
  assign rw_line = !rw_oe_n ? rw_out : host_owns ? host_read : ~last_rw;
  assign ready = ~slow | cnt[2];
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
// ----------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------
module tb_top
  import cpu_ctl_pkg::*;
;
  typedef struct packed {logic b; logic tim; logic row; logic iflag; logic start;
    logic [15:0] vec;} irq_row_s;
  logic        clk = 1'b0, rst = 1'b1, reset_in_n = 1'b0, nmi_n = 1'b1;
  logic        bus_handover_enable = 1'b1, ext_rom_select = 1'b0, core_i_flag = 1'b1;
  logic        src_timer = 1'b0, src_row_rx = 1'b0, host_read = 1'b1;
  logic        ext_pull_b = 1'b0, slow = 1'b0, got;
  logic [15:0] core_addr = 16'h0000, vec;
  logic [3:0]  seen;
  core_cycle_s core_cycle = '0;
  int_start_s  int_start;
  int          mismatches = 0, compares = 0, n, steps;
  logic        ready, maskable_request_a_in, maskable_request_b_in, rw_in;
  logic        maskable_request_a_out, maskable_request_a_oe_n, maskable_request_b_out;
  logic        maskable_request_b_oe_n, rw_out, rw_oe_n, addr_oe_n, data_oe_n, phi2, phi4;
  logic        sync, rmw_lock_out_n, core_step, core_halted, ext_access, ext_rw_read;
  logic        set_i_flag, test_mode, rom_to_external;
  // Line a via timer, both via row counter, b alone from outside
  irq_row_s rows [6] = '{'{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0000},
    '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000}, '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 16'hfffa},
    '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 16'hfffc}, '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 16'hfff8},
    '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 16'hfff8}};
  logic [17:0] rom_cases [4] = '{{1'b1, 16'hf7ff, 1'b0}, {1'b1, 16'hf800, 1'b1},
    {1'b1, 16'hffff, 1'b1}, {1'b0, 16'hffff, 1'b0}};

  always #25 clk = ~clk;

  cpu_int_bus_ctl cpu_int_bus_ctl_i (.clk, .rst, .reset_in_n, .nmi_n, .ready,
    .bus_handover_enable, .ext_rom_select, .maskable_request_a_in, .maskable_request_b_in,
    .maskable_request_a_out, .maskable_request_a_oe_n, .maskable_request_b_out,
    .maskable_request_b_oe_n, .rw_in, .rw_out, .rw_oe_n, .addr_oe_n, .data_oe_n, .phi2,
    .phi4, .sync, .rmw_lock_out_n, .core_cycle, .core_i_flag, .src_timer, .src_row_rx,
    .core_addr, .core_step, .core_halted, .ext_access, .ext_rw_read, .int_start,
    .set_i_flag, .test_mode, .rom_to_external);
  ext_side_model ext_side_model_i (.clk, .host_owns(!bus_handover_enable), .host_read,
    .ext_pull_b, .slow, .a_oe_n(maskable_request_a_oe_n), .b_oe_n(maskable_request_b_oe_n),
    .rw_out, .rw_oe_n, .a_pin(maskable_request_a_in), .b_pin(maskable_request_b_in),
    .rw_line(rw_in), .ready);

  // Inputs always move 5 ns after the edge
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #5;
  endtask

  task automatic wait_start(input int lim);
    got = 1'b0;
    for (n = 0; n < lim && !got; n++)
    begin
      tick(1);
      if (int_start.start === 1'b1)
      begin
        got = 1'b1;
        vec = int_start.vector;
      end
    end
  endtask

  // Counts steps and notes halt, sync, lock and data drive over k clocks
  task automatic watch(input int k);
    steps = 0;
    seen = 4'h0;
    repeat (k)
    begin
      tick(1);
      steps += (core_step === 1'b1);
      seen |= {~data_oe_n, core_halted, sync, ~rmw_lock_out_n};
    end
  endtask

  task automatic end_of_test();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Whole run is near 600 clocks; this leaves ample margin
  initial
  begin
    #(6000 * 50);
    mismatches++;
    end_of_test();
  end

  initial
  begin
    tick(6);
    rst = 1'b0;
    tick(2);
    reset_in_n = 1'b1;
    wait_start(60);
    `CHK(vec, 16'hffee)
    `CHK(n >= 20 && n <= 32, 1'b1)
    `CHK(test_mode, 1'b0)
    core_cycle.last_of_instr = 1'b1;
    foreach (rows[i])
    begin
      {ext_pull_b, src_timer, src_row_rx, core_i_flag} = rows[i][20:17];
      tick(2);
      `CHK(maskable_request_a_oe_n, !(rows[i].tim | rows[i].row))
      `CHK(maskable_request_b_oe_n, !rows[i].row)
      wait_start(40);
      `CHK(got, rows[i].start)
      if (got)
      begin
        `CHK(vec, rows[i].vec)
        `CHK(set_i_flag, 1'b1)
        tick(1);
        `CHK(set_i_flag, 1'b0)
      end
      {ext_pull_b, src_timer, src_row_rx, core_i_flag} = 4'h1;
      tick(12);
    end
    // Line held low while masked fires once the mask clears
    ext_pull_b = 1'b1;
    wait_start(16);
    `CHK(got, 1'b0)
    core_i_flag = 1'b0;
    wait_start(16);
    `CHK({got, vec}, {1'b1, 16'hfffa})
    {ext_pull_b, core_i_flag} = 2'h1;
    tick(8);
    // Edge only: a steady low must not fire twice
    nmi_n = 1'b0;
    wait_start(40);
    `CHK(got && int_start.is_nmi, 1'b1)
    `CHK(vec, 16'hffec)
    wait_start(40);
    `CHK(got, 1'b0)
    nmi_n = 1'b1;
    tick(8);
    nmi_n = 1'b0;
    wait_start(40);
    `CHK(got, 1'b1)
    nmi_n = 1'b1;
    `CHK(rw_out, 1'b0)
    core_cycle.read = 1'b1;
    watch(16);
    `CHK({steps, seen[2:0]}, {32'd4, 3'h0})
    `CHK({rw_out, rw_oe_n, maskable_request_b_out}, 3'h4)
    core_cycle.opcode_fetch = 1'b1;
    watch(16);
    `CHK(seen[2:0], 3'h2)
    core_cycle.opcode_fetch = 1'b0;
    core_cycle.rmw_modify = 1'b1;
    tick(8);
    watch(8);
    `CHK(seen[2:0], 3'h1)
    core_cycle.rmw_modify = 1'b0;
    core_cycle.rmw_write = 1'b1;
    tick(8);
    watch(8);
    `CHK(seen[2:0], 3'h1)
    core_cycle.rmw_write = 1'b0;
    slow = 1'b1;
    tick(8);
    watch(64);
    `CHK({seen[2], steps < 16}, 2'h3)
    slow = 1'b0;
    tick(8);
    watch(64);
    `CHK(steps, 16)
    bus_handover_enable = 1'b0;
    tick(4);
    watch(16);
    `CHK({steps, seen[3]}, {32'd0, 1'b1})
    `CHK({rw_oe_n, addr_oe_n, ext_access, ext_rw_read}, 4'hf)
    host_read = 1'b0;
    tick(2);
    watch(8);
    `CHK({ext_rw_read, seen[3]}, 2'h0)
    bus_handover_enable = 1'b1;
    host_read = 1'b1;
    tick(8);
    `CHK(rw_oe_n, 1'b0)
    // Low bus enable across the release selects the test mode
    reset_in_n = 1'b0;
    bus_handover_enable = 1'b0;
    tick(4);
    reset_in_n = 1'b1;
    tick(3);
    bus_handover_enable = 1'b1;
    wait_start(60);
    `CHK({vec, test_mode}, {16'hffee, 1'b1})
    foreach (rom_cases[i])
    begin
      {ext_rom_select, core_addr} = rom_cases[i][17:1];
      tick(3);
      `CHK(rom_to_external, rom_cases[i][0])
    end
    end_of_test();
  end
endmodule
`default_nettype wire
